// ===== fpet_regs.svh
// Timing constants for the flash program/erase sequencer
`ifndef FPET_REGS_SVH
`define FPET_REGS_SVH
`define FPET_T_WORD       14'd30
`define FPET_T_BLK_FIRST  14'd25
`define FPET_T_BLK_NEXT   14'd18
`define FPET_T_BLK_END    14'd6
`define FPET_T_MASS_ERASE 14'd10593
`define FPET_T_SEG_ERASE  14'd4819
`define FPET_BLK_MAX      7'd64
`define FPET_UNITS_NONE   7'd0
`define FPET_UNITS_ONE    7'd1
`define FPET_CNT_ZERO     14'd0
`define FPET_CNT_ONE      14'd1
`endif

// ===== fpet_pkg.sv
// Types for the flash program/erase sequencer
package fpet_pkg;
  typedef enum logic [2:0] {
    FPET_OP_WORD  = 3'b000,
    FPET_OP_BLOCK = 3'b001,
    FPET_OP_SEG   = 3'b010,
    FPET_OP_MASS  = 3'b011
  } fpet_op_t;
  typedef enum logic [2:0] {
    FPET_IDLE      = 3'b000,
    FPET_WORD      = 3'b001,
    FPET_BLK_FIRST = 3'b010,
    FPET_BLK_NEXT  = 3'b011,
    FPET_BLK_WAIT  = 3'b100,
    FPET_BLK_END   = 3'b101,
    FPET_ERASE     = 3'b110
  } fpet_state_t;
endpackage

// ===== fpet_tick_sync.sv
// Synchroniser and rising-edge detector for the timing generator clock
module fpet_tick_sync (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic level_i,
  output logic      rise_o
);
  logic meta_r;
  logic sync_r;
  logic last_r;

  // Only sync_r looks at meta_r
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
      rise_o <= 1'b0;
    end else begin
      meta_r <= level_i;
      sync_r <= meta_r;
      last_r <= sync_r;
      rise_o <= sync_r & ~last_r;
    end
  end
endmodule // fpet_tick_sync

// ===== fpet_seq.sv
// Flash program/erase timing sequencer
// Function
// R1 - Single word or byte program lasts 30 timing clock periods.
// R2 - Block program spends 25 periods on the first unit.
// R3 - Each further block unit, up to 63 more, takes 18 periods.
// R4 - After the last block unit, a 6-period end wait runs.
// R5 - Mass erase keeps the erase phase active for 10593 periods.
// R6 - Segment erase keeps the erase phase active for 4819 periods.
// R7 - All phase lengths are fixed constants, not software adjustable.
// R8 - Software keeps the timing clock between 257 and 476 kHz.
// R9 - Software keeps cumulative program time per 64-byte block within 10 ms.
// R10 - Software repeats mass erase until at least 20 ms accumulate.
// R11 - Busy while counting; no new operation starts until completion.
// R12 - Reset aborts any operation, clears the counter, returns to idle.
`include "fpet_regs.svh"
module fpet_seq
  import fpet_pkg::*;
#(
  parameter int BLK_UNITS = `FPET_BLK_MAX
)
(
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       flash_timing_clock_i,
  input  wire logic       start_i,
  input  wire logic [2:0] op_i,
  input  wire logic       unit_valid_i,
  input  wire logic       block_last_i,
  output logic            busy_o,
  output logic            prog_o,
  output logic            erase_o,
  output logic            unit_ack_o,
  output logic            done_o
);
  fpet_state_t state_r;
  fpet_state_t state_nxt;
  logic [13:0] cnt_r;
  logic [13:0] cnt_nxt;
  logic [6:0]  units_r;
  logic        last_r;
  logic        tick;
  logic        expire;
  logic        ack_nxt;
  logic        done_nxt;
  logic        unit_take;

  // Unit counter is seven bits wide, enough to count a full block of 64 units
  localparam logic [6:0] BLK_LAST = 7'(BLK_UNITS);

  // Refuse block sizes the unit counter cannot serve
  if (BLK_UNITS < `FPET_UNITS_ONE || BLK_UNITS > `FPET_BLK_MAX) begin : g_bad_units
    $error("fpet_seq: BLK_UNITS out of range");
  end

  // Program level covers the hold between block units as well
  function automatic logic is_prog(input fpet_state_t s);
    is_prog = (s == FPET_WORD) || (s == FPET_BLK_FIRST) || (s == FPET_BLK_NEXT)
              || (s == FPET_BLK_WAIT);
  endfunction

  // A new block unit is taken only while holding between units
  assign unit_take = (state_r == FPET_BLK_WAIT) && unit_valid_i;

  // Edges of the slow timing clock pace every phase; 2-flop sync inside
  fpet_tick_sync u_tick (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .level_i (flash_timing_clock_i),
    .rise_o  (tick)
  );

  // Phase counter ends on the tick that completes its last period
  assign expire = tick && (cnt_r == `FPET_CNT_ONE);

  // Start accepted only from idle; requests while busy are ignored
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    ack_nxt   = 1'b0;
    done_nxt  = 1'b0;
    case (state_r)
      FPET_IDLE: begin
        if (start_i) begin // R11
          case (op_i)
            FPET_OP_WORD: begin
              state_nxt = FPET_WORD;
              cnt_nxt   = `FPET_T_WORD; // R1 R7
            end
            FPET_OP_BLOCK: begin
              state_nxt = FPET_BLK_FIRST;
              cnt_nxt   = `FPET_T_BLK_FIRST; // R2 R7
            end
            FPET_OP_SEG: begin
              state_nxt = FPET_ERASE;
              cnt_nxt   = `FPET_T_SEG_ERASE; // R6 R7
            end
            FPET_OP_MASS: begin
              state_nxt = FPET_ERASE;
              cnt_nxt   = `FPET_T_MASS_ERASE; // R5 R7
            end
            default: state_nxt = FPET_IDLE;
          endcase
        end
      end
      FPET_WORD, FPET_ERASE, FPET_BLK_END: begin
        if (tick) begin
          cnt_nxt = cnt_r - `FPET_CNT_ONE;
        end
        if (expire) begin
          state_nxt = FPET_IDLE;
          done_nxt  = 1'b1;
        end
      end
      FPET_BLK_FIRST, FPET_BLK_NEXT: begin
        if (tick) begin
          cnt_nxt = cnt_r - `FPET_CNT_ONE;
        end
        if (expire) begin
          ack_nxt = 1'b1;
          if (last_r || units_r == BLK_LAST) begin
            state_nxt = FPET_BLK_END;
            cnt_nxt   = `FPET_T_BLK_END; // R4
          end else begin
            state_nxt = FPET_BLK_WAIT;
          end
        end
      end
      FPET_BLK_WAIT: begin
        // Programming voltage held between units; waits for next data
        if (unit_valid_i) begin
          state_nxt = FPET_BLK_NEXT;
          cnt_nxt   = `FPET_T_BLK_NEXT; // R3
        end else if (block_last_i) begin
          state_nxt = FPET_BLK_END;
          cnt_nxt   = `FPET_T_BLK_END; // R4
        end
      end
      default: begin
        state_nxt = FPET_IDLE;
        cnt_nxt   = `FPET_CNT_ZERO;
      end
    endcase
  end

  // Sequencer state
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= FPET_IDLE; // R12
    end else begin
      state_r <= state_nxt;
    end
  end

  // Phase counter; cleared by reset so a cut phase never resumes
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= `FPET_CNT_ZERO; // R12
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Units already taken in the running block
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      units_r <= `FPET_UNITS_NONE;
    end else if (state_r == FPET_IDLE) begin
      units_r <= `FPET_UNITS_ONE;
    end else if (unit_take) begin
      units_r <= units_r + `FPET_UNITS_ONE; // R3
    end
  end

  // Last-unit mark follows the unit it was given with
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      last_r <= 1'b0;
    end else if (state_r == FPET_IDLE || unit_take) begin
      last_r <= block_last_i; // R4
    end
  end

  // busy_o, prog_o and erase_o decode the next state so they line up with state_r
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= (state_nxt != FPET_IDLE); // R11
    end
  end

  // End wait drops the program level, so prog_o falls before done_o
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prog_o <= 1'b0;
    end else begin
      prog_o <= is_prog(state_nxt);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      erase_o <= 1'b0;
    end else begin
      erase_o <= (state_nxt == FPET_ERASE);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      unit_ack_o <= 1'b0;
    end else begin
      unit_ack_o <= ack_nxt;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_o <= 1'b0;
    end else begin
      done_o <= done_nxt;
    end
  end
endmodule // fpet_seq

// ===== fpet_seq_sva.sv
// Port checker for the program/erase sequencer
module fpet_seq_chk
  import fpet_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire logic       start_i,
  input wire logic [2:0] op_i,
  input wire logic       busy_o,
  input wire logic       prog_o,
  input wire logic       erase_o,
  input wire logic       unit_ack_o,
  input wire logic       done_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_take(logic [2:0] k); start_i && !busy_o && op_i == k; endsequence
  property p_word; s_take(FPET_OP_WORD) |=> busy_o && prog_o && !erase_o; endproperty
  property p_seg; s_take(FPET_OP_SEG) |=> busy_o && erase_o && !prog_o; endproperty
  property p_mass; s_take(FPET_OP_MASS) |=> (busy_o && erase_o) [*8]; endproperty
  property p_end; $fell(busy_o) |-> done_o && !prog_o && !erase_o; endproperty
  property p_done; done_o |=> !done_o; endproperty
  property p_ack; unit_ack_o |-> busy_o && !erase_o ##1 !unit_ack_o; endproperty
  property p_phase; (prog_o || erase_o) |-> busy_o && !(prog_o && erase_o); endproperty
  property p_rst; $rose(rst_n_i) |-> !busy_o && !prog_o && !erase_o && !done_o; endproperty
  a_word: assert property (p_word) else $error("word start");
  a_seg: assert property (p_seg) else $error("segment start");
  a_mass: assert property (p_mass) else $error("mass start");
  a_end: assert property (p_end) else $error("end of op");
  a_done: assert property (p_done) else $error("done width");
  a_ack: assert property (p_ack) else $error("unit ack");
  a_phase: assert property (p_phase) else $error("phase levels");
  a_rst: assert property (p_rst) else $error("reset state");
endmodule // fpet_seq_chk
bind fpet_seq fpet_seq_chk u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .start_i(start_i),
  .op_i(op_i), .busy_o(busy_o), .prog_o(prog_o), .erase_o(erase_o),
  .unit_ack_o(unit_ack_o), .done_o(done_o));

// ===== fpet_ftg_model.sv
// Scaled timing generator clock source
module fpet_tclk_model (
  input  wire logic clk_i,
  output logic      tclk_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Five clocks a period keeps the run short; real range is 257 to 476 kHz
  logic [2:0] ph_r = 3'h0;
  always_ff @(posedge clk_i) ph_r <= (ph_r == 3'h4) ? 3'h0 : ph_r + 3'h1;
  assign tclk_o = ph_r < 3'h2;
endmodule // fpet_tclk_model

// ===== flash_program_erase_timing_tb.sv
// Bench for the program/erase sequencer
module flash_program_erase_timing_tb;
  import fpet_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_total++; \
  $display("BAD %0t %h %h", $time, a, e); end end
  logic       clk_i = 1'h0, rst_n_i = 1'h0, start_i = 1'h0, vld = 1'h0, tclk, tclk_q = 1'h0;
  logic       lst = 1'h0;
  logic [2:0] op_i = 3'h0;
  logic       busy_o, prog_o, erase_o, unit_ack_o, done_o;
  int         err_total = 0, n_tests = 0, cyc = 0, cnt = 0, q[$];
  fpet_tclk_model u_tclk (.clk_i(clk_i), .tclk_o(tclk));
  fpet_seq u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .flash_timing_clock_i(tclk),
    .start_i(start_i), .op_i(op_i), .unit_valid_i(vld), .block_last_i(lst),
    .busy_o(busy_o), .prog_o(prog_o), .erase_o(erase_o), .unit_ack_o(unit_ack_o),
    .done_o(done_o));
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  // Timing edges between events; starts are aligned so sync lag never blurs the count
  always @(posedge clk_i) begin
    cyc++;
    tclk_q <= tclk;
    if (start_i && !busy_o) cnt = 0;
    if (tclk && !tclk_q) cnt++;
    if (unit_ack_o || done_o) begin
      q.push_back(cnt);
      cnt = 0;
    end
    if (cyc > 95000) begin
      err_total++;
      report_and_stop();
    end
  end
  task automatic go(input logic [2:0] op);
    q.delete();
    @(posedge clk_i);
    while (!(tclk && !tclk_q)) @(posedge clk_i);
    repeat (3) @(posedge clk_i);
    start_i <= 1'h1;
    op_i <= op;
    @(posedge clk_i);
    start_i <= 1'h0;
  endtask
  task automatic wt(input int lim);
    int w;
    w = 0;
    while (w < lim && done_o !== 1'h1) begin
      @(posedge clk_i);
      w++;
    end
    `CHK(done_o, 1'h1)
    #1;
  endtask
  task automatic t_op(input logic [2:0] op, input int n);
    go(op);
    wt(n * 5 + 100);
    `CHK(q[0], n)
    $display("op %0d end", op);
  endtask
  task automatic t_busy;
    @(posedge clk_i);
    start_i <= 1'h1;
    op_i <= 3'h5;
    @(posedge clk_i);
    start_i <= 1'h0;
    @(posedge clk_i);
    #1 `CHK(busy_o, 1'h0)
    go(FPET_OP_WORD);
    repeat (20) @(posedge clk_i);
    start_i <= 1'h1;
    op_i <= FPET_OP_MASS;
    @(posedge clk_i);
    start_i <= 1'h0;
    wt(400);
    `CHK(q[0], 30)
    repeat (3) @(posedge clk_i);
    #1 `CHK(busy_o, 1'h0)
    $display("busy end");
  endtask
  task automatic t_reset;
    go(FPET_OP_SEG);
    repeat (50) @(posedge clk_i);
    #1 `CHK(erase_o, 1'h1)
    @(posedge clk_i);
    rst_n_i <= 1'h0;
    @(posedge clk_i);
    #1 `CHK({busy_o, erase_o}, 2'h0)
    @(posedge clk_i);
    rst_n_i <= 1'h1;
    $display("reset end");
  endtask
  // Last mark given with the start, or raised alone after the start and seen while holding between units
  task automatic t_short(input logic at_start);
    @(posedge clk_i);
    lst <= at_start;
    go(FPET_OP_BLOCK);
    lst <= 1'h1;
    wt(400);
    `CHK(q.size(), 2)
    `CHK(q[0], 25)
    `CHK(q[1], 6)
    @(posedge clk_i);
    lst <= 1'h0;
    $display("short block end");
  endtask
  task automatic t_block;
    @(posedge clk_i);
    vld <= 1'h1;
    go(FPET_OP_BLOCK);
    // Full block is the slowest program case, well inside the cumulative limit
    wt(9000);
    @(posedge clk_i);
    vld <= 1'h0;
    `CHK(q.size(), 65)
    `CHK(q[0], 25)
    for (int i = 1; i < 64; i++) `CHK(q[i], 18)
    `CHK(q[64], 6)
    $display("block end");
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'h1;
    t_reset();
    t_op(FPET_OP_WORD, 30);
    t_busy();
    t_short(1'h1);
    t_short(1'h0);
    t_block();
    t_op(FPET_OP_SEG, 4819);
    // One mass erase already spans more than the minimum cumulative time
    t_op(FPET_OP_MASS, 10593);
    report_and_stop();
  end
  task automatic report_and_stop;
    $display("tests %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
endmodule // flash_program_erase_timing_tb
